// ---- common/clk_ctrl_pkg.sv ----
/*
 constants, register map and state type of the clock and suspend
 control block.
 assumes a 200 MHz core clock; all times are converted to cycles here.
*/
package clk_ctrl_pkg;
   // ==========================================================
   // clocks
   localparam int unsigned CORE_MHZ = 200;
   localparam int unsigned REF_MHZ = 6;
   localparam int unsigned PLL_MHZ = 48;
   localparam int unsigned PLL_MUL = PLL_MHZ / REF_MHZ;
   // two toggle ticks per pll period, as a phase step per core cycle
   localparam int unsigned PLL_STEP = 2 * REF_MHZ * PLL_MUL;
   localparam int unsigned PLL_MOD = CORE_MHZ;
   localparam int unsigned ACC_W = 9;
   localparam int unsigned DIV_W = 4;
   localparam int unsigned LAZY_HZ = 24000;
   // ==========================================================
   // times and cycle counts
   localparam int unsigned SUSP_DELAY_US = 2000;
   localparam int unsigned WAKE_DELAY_US = 500;
   localparam int unsigned CLK_START_US = 500;
   localparam int unsigned CLK_SETTLE_US = 4000;
   localparam int unsigned POR_LOW_US = 50;
   localparam int unsigned SUSP_DELAY_CYC = SUSP_DELAY_US * CORE_MHZ;
   localparam int unsigned WAKE_DELAY_CYC = WAKE_DELAY_US * CORE_MHZ;
   localparam int unsigned CLK_START_CYC = CLK_START_US * CORE_MHZ;
   localparam int unsigned SETTLE_CYC =
      (CLK_SETTLE_US - CLK_START_US) * CORE_MHZ;
   localparam int unsigned POR_LOW_CYC = POR_LOW_US * CORE_MHZ;
   localparam int unsigned LAZY_HALF_CYC =
      CORE_MHZ * 1000000 / (2 * LAZY_HZ);
   localparam int unsigned CNT_W = 24;
   localparam int unsigned LAZY_W = 16;
   localparam int unsigned POR_W = 20;
   // ==========================================================
   // register map
   localparam int unsigned ADDR_W = 4;
   localparam logic [3:0] REG_CONFIG = 4'h0;
   localparam logic [3:0] REG_MODE = 4'h4;
   localparam logic [3:0] REG_STATUS = 4'h8;
   localparam logic [3:0] REG_EP_CFG = 4'hC;
   localparam int unsigned CFG_OSC_RUN_BIT = 0;
   localparam int unsigned CFG_SLOW_DIS_BIT = 1;
   localparam int unsigned CFG_DIV_LSB = 4;
   localparam int unsigned MODE_SLEEP_BIT = 0;
   localparam int unsigned STAT_SLEEP_BIT = 0;
   localparam int unsigned STAT_OSC_BIT = 1;
   localparam int unsigned STAT_STABLE_BIT = 2;
   localparam int unsigned STAT_POR_BIT = 3;
   localparam int unsigned STAT_BUSY_BIT = 4;
   localparam logic CFG_OSC_RUN_RST = 1'h1;
   localparam logic CFG_SLOW_DIS_RST = 1'h0;
   localparam logic [DIV_W-1:0] CFG_DIV_RST = 4'h0;
   localparam int unsigned EP_W = 16;
   localparam logic [EP_W-1:0] EP_CFG_RST = 16'h0001;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [2:0] {
      ST_POWERUP, ST_RUN, ST_ENTER, ST_SLEEP, ST_WAKE
   } state_t;
endpackage

// ---- common/div_if.sv ----
/*
 link between the sequencer and the output clock divider.
 assumes both ends run on the core clock.
*/
interface div_if
   import clk_ctrl_pkg::*;
;
   logic tick;
   logic run;
   logic [DIV_W-1:0] div;
   logic lvl;
   modport ctrl (output tick, output run, output div, input lvl);
   modport gen (input tick, input run, input div, output lvl);
endinterface

// ---- src/clk_divider.sv ----
/*
 programmable divider of the 48 MHz toggle ticks.
 assumes ticks come as one-cycle enables on the core clock.
*/
module clk_divider
   import clk_ctrl_pkg::*;
(
   input wire logic clk_in,
   input wire logic rst_in,
   div_if.gen dv
);
   // ==========================================================
   // divider
   logic [DIV_W-1:0] cnt_ff;
   logic [DIV_W-1:0] nxt_cnt;
   logic lvl_ff;
   logic nxt_lvl;
   wire last = (cnt_ff >= dv.div);

   // toggle every (div+1) ticks: 48 MHz / (div+1) at the pin  [R13]
   // a count left above a freshly lowered field restarts at once
   assign nxt_cnt = !dv.run ? '0 : (cnt_ff > dv.div) ? '0 :
                    !dv.tick ? cnt_ff : last ? '0 : cnt_ff + DIV_W'(1);
   assign nxt_lvl = !dv.run ? 1'h0 : (dv.tick && last) ? ~lvl_ff : lvl_ff;
   assign dv.lvl = lvl_ff;

   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         cnt_ff <= '0;
         lvl_ff <= 1'h0;
      end else begin
         cnt_ff <= nxt_cnt;
         lvl_ff <= nxt_lvl;
      end
   end

   // ==========================================================
   // checks
   a_div_toggle: assert property (@(posedge clk_in) disable iff (rst_in)
      dv.run && dv.tick && cnt_ff == dv.div ##1 dv.run
      |-> lvl_ff != $past(lvl_ff))  // [R13]
      else $error("divider missed its toggle");
   a_div_hold: assert property (@(posedge clk_in) disable iff (rst_in)
      dv.run && !dv.tick |=> $stable(lvl_ff))  // [R2]
      else $error("divider toggled without a tick");
   a_div_bound: assert property (@(posedge clk_in) disable iff (rst_in)
      $stable(dv.div) && dv.run |-> cnt_ff <= dv.div)  // [R5]
      else $error("divider count above its field");
endmodule

// ---- src/clock_suspend_ctrl.sv ----
/*
 clock generation and suspend/resume sequencing of a full-speed usb
 device, with its configuration reached over axi4-lite.
 assumes one 200 MHz core clock, active-high async reset, and that
 WAKE_IN and VCC_LOW_IN are asynchronous pins.
*/
// Local design decisions: the AXI4-Lite interface to the registers and the register offsets.
// Behaviour
// (R1) pll multiplies 6 MHz reference to a 48 MHz internal clock.
// (R2) clock output is derived from 48 MHz, 3 to 48 MHz.
// (R3) suspend switches oscillator and pll off; normal clock gone.
// (R4) oscillator run bit turns oscillator on when set, off when clear.
// (R5) four-bit divider field sets the normal clock output rate.
// (R6) slow clock disable decides if slow clock shows in suspend.
// (R7) firmware sets then clears sleep bit; outputs change ~2 ms later.
// (R8) slow clock disable 0: output runs at 24 kHz during suspend.
// (R9) resume pulse clears sleep output, restarts clock after 0.5 ms.
// (R10) clock output starts 0.5 ms after power-on, stable by 4 ms.
// (R11) supply low longer than 50 us raises an internal reset.
// (R12) hardware reset clears endpoint configs; control endpoint stays on.
// (R13) normal output frequency is 48 MHz over divider value plus one.
// (R14) slow clock disable 1: output static for the whole suspend.
module clock_suspend_ctrl
   import clk_ctrl_pkg::*;
#(
   parameter int unsigned SUSP_CYC = SUSP_DELAY_CYC,
   parameter int unsigned WAKE_CYC = WAKE_DELAY_CYC,
   parameter int unsigned START_CYC = CLK_START_CYC,
   parameter int unsigned STABLE_CYC = SETTLE_CYC,
   parameter int unsigned POR_CYC = POR_LOW_CYC,
   parameter int unsigned LAZY_CYC = LAZY_HALF_CYC
)(
   input wire logic CORE_CLK_IN,
   input wire logic SYS_RST_IN,
   input wire logic AXI_AWVALID_IN,
   output logic AXI_AWREADY_OUT,
   input wire logic [ADDR_W-1:0] AXI_AWADDR_IN,
   input wire logic AXI_WVALID_IN,
   output logic AXI_WREADY_OUT,
   input wire logic [31:0] AXI_WDATA_IN,
   input wire logic [3:0] AXI_WSTRB_IN,
   output logic AXI_BVALID_OUT,
   input wire logic AXI_BREADY_IN,
   output logic [1:0] AXI_BRESP_OUT,
   input wire logic AXI_ARVALID_IN,
   output logic AXI_ARREADY_OUT,
   input wire logic [ADDR_W-1:0] AXI_ARADDR_IN,
   output logic AXI_RVALID_OUT,
   input wire logic AXI_RREADY_IN,
   output logic [31:0] AXI_RDATA_OUT,
   output logic [1:0] AXI_RRESP_OUT,
   input wire logic WAKE_IN,
   input wire logic VCC_LOW_IN,
   output logic CLK_OUT,
   output logic SLEEP_OUT,
   output logic OSC_EN_OUT,
   output logic PLL_EN_OUT,
   output logic CLK_STABLE_OUT,
   output logic [EP_W-1:0] EP_ENABLE_OUT
);
   default clocking cb @(posedge CORE_CLK_IN); endclocking
   default disable iff (SYS_RST_IN);

   // ==========================================================
   // pin synchronisers
   logic [1:0] wake_sync_ff;
   logic [1:0] vlow_sync_ff;
   logic wake_prev_ff;
   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         wake_sync_ff <= 2'h0;
         vlow_sync_ff <= 2'h0;
         wake_prev_ff <= 1'h0;
      end else begin
         wake_sync_ff <= {wake_sync_ff[0], WAKE_IN};
         vlow_sync_ff <= {vlow_sync_ff[0], VCC_LOW_IN};
         wake_prev_ff <= wake_sync_ff[1];
      end
   end
   wire wake_rise = wake_sync_ff[1] & ~wake_prev_ff;
   wire vlow = vlow_sync_ff[1];

   // ==========================================================
   // power-on reset from a long supply dip
   logic [POR_W-1:0] por_cnt_ff;
   logic [POR_W-1:0] nxt_por_cnt;
   // held while supply stays low past the window  [R11]
   wire por_hold = vlow && (por_cnt_ff == POR_W'(POR_CYC));
   assign nxt_por_cnt = !vlow ? '0 : por_hold ? por_cnt_ff :
                        por_cnt_ff + POR_W'(1);
   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         por_cnt_ff <= '0;
      end else begin
         por_cnt_ff <= nxt_por_cnt;
      end
   end

   // ==========================================================
   // axi4-lite write side
   logic aw_held_ff;
   logic w_held_ff;
   logic bvalid_ff;
   logic [1:0] bresp_ff;
   logic [ADDR_W-1:0] awaddr_ff;
   logic [31:0] wdata_ff;
   logic [3:0] wstrb_ff;
   assign AXI_AWREADY_OUT = !aw_held_ff && !bvalid_ff;
   assign AXI_WREADY_OUT = !w_held_ff && !bvalid_ff;
   assign AXI_BVALID_OUT = bvalid_ff;
   assign AXI_BRESP_OUT = bresp_ff;
   wire aw_take = AXI_AWVALID_IN && AXI_AWREADY_OUT;
   wire w_take = AXI_WVALID_IN && AXI_WREADY_OUT;
   wire wr_go = aw_held_ff && w_held_ff;
   wire wsel_cfg = (awaddr_ff == REG_CONFIG);
   wire wsel_mode = (awaddr_ff == REG_MODE);
   wire wsel_stat = (awaddr_ff == REG_STATUS);
   wire wsel_ep = (awaddr_ff == REG_EP_CFG);
   wire wr_mapped = wsel_cfg | wsel_mode | wsel_stat | wsel_ep;
   wire [31:0] wmask = {{8{wstrb_ff[3]}}, {8{wstrb_ff[2]}},
                        {8{wstrb_ff[1]}}, {8{wstrb_ff[0]}}};

   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         aw_held_ff <= 1'h0;
         w_held_ff <= 1'h0;
         bvalid_ff <= 1'h0;
         bresp_ff <= RESP_OKAY;
         awaddr_ff <= '0;
         wdata_ff <= 32'h0;
         wstrb_ff <= 4'h0;
      end else begin
         if (aw_take) begin
            aw_held_ff <= 1'h1;
            awaddr_ff <= AXI_AWADDR_IN;
         end else if (wr_go) begin
            aw_held_ff <= 1'h0;
         end
         if (w_take) begin
            w_held_ff <= 1'h1;
            wdata_ff <= AXI_WDATA_IN;
            wstrb_ff <= AXI_WSTRB_IN;
         end else if (wr_go) begin
            w_held_ff <= 1'h0;
         end
         if (wr_go) begin
            bvalid_ff <= 1'h1;
            bresp_ff <= wr_mapped ? RESP_OKAY : RESP_SLVERR;
         end else if (AXI_BREADY_IN) begin
            bvalid_ff <= 1'h0;
         end
      end
   end

   // ==========================================================
   // control registers
   logic osc_run_ff;
   logic slow_dis_ff;
   logic [DIV_W-1:0] div_ff;
   logic sleep_bit_ff;
   logic sleep_bit_prev_ff;
   logic [EP_W-1:1] ep_cfg_ff;
   logic por_seen_ff;
   logic stable_ff;
   state_t state_ff;
   logic [CNT_W-1:0] cnt_ff;
   wire [31:0] cfg_word = (32'(osc_run_ff) << CFG_OSC_RUN_BIT) |
                          (32'(slow_dis_ff) << CFG_SLOW_DIS_BIT) |
                          (32'(div_ff) << CFG_DIV_LSB);
   wire [31:0] mode_word = 32'(sleep_bit_ff) << MODE_SLEEP_BIT;
   wire [31:0] ep_word = 32'({ep_cfg_ff, 1'h1});
   wire [31:0] cfg_new = (cfg_word & ~wmask) | (wdata_ff & wmask);
   wire [31:0] mode_new = (mode_word & ~wmask) | (wdata_ff & wmask);
   wire [31:0] ep_new = (ep_word & ~wmask) | (wdata_ff & wmask);
   wire wr_cfg = wr_go && wsel_cfg;
   wire wr_mode = wr_go && wsel_mode;
   wire wr_ep = wr_go && wsel_ep;
   wire por_clr = wr_go && wsel_stat && wmask[STAT_POR_BIT] &&
                  wdata_ff[STAT_POR_BIT];

   // supply dip clears configuration like a hardware reset  [R11]
   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         osc_run_ff <= CFG_OSC_RUN_RST;
         slow_dis_ff <= CFG_SLOW_DIS_RST;
         div_ff <= CFG_DIV_RST;
         sleep_bit_ff <= 1'h0;
         ep_cfg_ff <= EP_CFG_RST[EP_W-1:1];
      end else if (por_hold) begin
         osc_run_ff <= CFG_OSC_RUN_RST;
         slow_dis_ff <= CFG_SLOW_DIS_RST;
         div_ff <= CFG_DIV_RST;
         sleep_bit_ff <= 1'h0;
         ep_cfg_ff <= EP_CFG_RST[EP_W-1:1];  // [R12]
      end else begin
         if (wr_cfg) begin
            osc_run_ff <= cfg_new[CFG_OSC_RUN_BIT];  // [R4]
            slow_dis_ff <= cfg_new[CFG_SLOW_DIS_BIT];  // [R6]
            div_ff <= cfg_new[CFG_DIV_LSB +: DIV_W];  // [R5]
         end
         if (wr_mode) begin
            sleep_bit_ff <= mode_new[MODE_SLEEP_BIT];
         end
         if (wr_ep) begin
            ep_cfg_ff <= ep_new[EP_W-1:1];
         end
      end
   end

   // dip flag: a new dip wins over a clear in the same cycle
   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         por_seen_ff <= 1'h0;
         sleep_bit_prev_ff <= 1'h0;
      end else begin
         por_seen_ff <= por_hold | (por_seen_ff & ~por_clr);
         sleep_bit_prev_ff <= sleep_bit_ff;
      end
   end
   // ==========================================================
   // axi4-lite read side
   logic rvalid_ff;
   logic [31:0] rdata_ff;
   logic [1:0] rresp_ff;
   assign AXI_ARREADY_OUT = !rvalid_ff;
   assign AXI_RVALID_OUT = rvalid_ff;
   assign AXI_RDATA_OUT = rdata_ff;
   assign AXI_RRESP_OUT = rresp_ff;
   wire ar_take = AXI_ARVALID_IN && AXI_ARREADY_OUT;
   wire busy = (state_ff == ST_ENTER) || (state_ff == ST_WAKE);
   wire [31:0] stat_word = (32'(SLEEP_OUT) << STAT_SLEEP_BIT) |
                           (32'(OSC_EN_OUT) << STAT_OSC_BIT) |
                           (32'(stable_ff) << STAT_STABLE_BIT) |
                           (32'(por_seen_ff) << STAT_POR_BIT) |
                           (32'(busy) << STAT_BUSY_BIT);
   wire rsel_cfg = (AXI_ARADDR_IN == REG_CONFIG);
   wire rsel_mode = (AXI_ARADDR_IN == REG_MODE);
   wire rsel_stat = (AXI_ARADDR_IN == REG_STATUS);
   wire rsel_ep = (AXI_ARADDR_IN == REG_EP_CFG);
   wire rd_mapped = rsel_cfg | rsel_mode | rsel_stat | rsel_ep;
   wire [31:0] rd_word = rsel_cfg ? cfg_word : rsel_mode ? mode_word :
                         rsel_stat ? stat_word : rsel_ep ? ep_word : 32'h0;

   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         rvalid_ff <= 1'h0;
         rdata_ff <= 32'h0;
         rresp_ff <= RESP_OKAY;
      end else if (ar_take) begin
         rvalid_ff <= 1'h1;
         rdata_ff <= rd_word;
         rresp_ff <= rd_mapped ? RESP_OKAY : RESP_SLVERR;
      end else if (AXI_RREADY_IN) begin
         rvalid_ff <= 1'h0;
      end
   end
   // ==========================================================
   // suspend / resume sequencer
   state_t nxt_state;
   logic [CNT_W-1:0] nxt_cnt;
   wire sleep_fall = sleep_bit_prev_ff & ~sleep_bit_ff;
   wire cnt_inc = (state_ff != ST_SLEEP);
   always_comb begin
      nxt_state = state_ff;
      nxt_cnt = cnt_inc ? cnt_ff + CNT_W'(1) : cnt_ff;
      case (state_ff)
         ST_POWERUP: begin
            if (cnt_ff == CNT_W'(START_CYC - 1)) begin  // [R10]
               nxt_state = ST_RUN;
               nxt_cnt = '0;
            end
         end
         ST_RUN: begin
            if (sleep_fall) begin  // [R7]
               nxt_state = ST_ENTER;
               nxt_cnt = '0;
            end else if (!osc_run_ff) begin
               nxt_cnt = '0;
            end else if (stable_ff) begin
               nxt_cnt = cnt_ff;
            end
         end
         ST_ENTER: begin
            if (cnt_ff == CNT_W'(SUSP_CYC - 1)) begin  // [R7]
               nxt_state = ST_SLEEP;
               nxt_cnt = '0;
            end
         end
         ST_SLEEP: begin
            if (wake_rise) begin  // [R9]
               nxt_state = ST_WAKE;
               nxt_cnt = '0;
            end
         end
         ST_WAKE: begin
            if (cnt_ff == CNT_W'(WAKE_CYC - 1)) begin  // [R9]
               nxt_state = ST_RUN;
               nxt_cnt = '0;
            end
         end
         default: begin
            nxt_state = ST_POWERUP;
            nxt_cnt = '0;
         end
      endcase
   end
   wire nxt_sleep = (nxt_state == ST_SLEEP) || (nxt_state == ST_WAKE);
   // oscillator and pll off while asleep or while the run bit is clear  [R3] [R4]
   wire nxt_osc = osc_run_ff && (nxt_state != ST_SLEEP);
   wire nxt_stable = nxt_osc && (nxt_state == ST_RUN) &&
                     (stable_ff || cnt_ff == CNT_W'(STABLE_CYC - 1));
   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         state_ff <= ST_POWERUP;
         cnt_ff <= '0;
         SLEEP_OUT <= 1'h0;
         OSC_EN_OUT <= 1'h0;
         stable_ff <= 1'h0;
      end else if (por_hold) begin
         state_ff <= ST_POWERUP;
         cnt_ff <= '0;
         SLEEP_OUT <= 1'h0;
         OSC_EN_OUT <= 1'h0;
         stable_ff <= 1'h0;
      end else begin
         state_ff <= nxt_state;
         cnt_ff <= nxt_cnt;
         SLEEP_OUT <= nxt_sleep;
         OSC_EN_OUT <= nxt_osc;
         stable_ff <= nxt_stable;
      end
   end
   assign PLL_EN_OUT = OSC_EN_OUT;
   assign CLK_STABLE_OUT = stable_ff;
   assign EP_ENABLE_OUT = {ep_cfg_ff, 1'h1};  // [R12]

   // ==========================================================
   // pll model: toggle ticks at twice 48 MHz
   logic [ACC_W-1:0] acc_ff;
   wire [ACC_W-1:0] acc_sum = acc_ff + ACC_W'(PLL_STEP);
   wire pll_tick = PLL_EN_OUT && (acc_sum >= ACC_W'(PLL_MOD));  // [R1]
   wire [ACC_W-1:0] nxt_acc = !PLL_EN_OUT ? '0 :
                              pll_tick ? acc_sum - ACC_W'(PLL_MOD) : acc_sum;
   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         acc_ff <= '0;
      end else begin
         acc_ff <= nxt_acc;
      end
   end

   div_if dv ();
   assign dv.tick = pll_tick;
   assign dv.run = PLL_EN_OUT &&
                   (state_ff == ST_RUN || state_ff == ST_ENTER);  // [R2]
   assign dv.div = div_ff;  // [R5]
   clk_divider u_div (
      .clk_in (CORE_CLK_IN),
      .rst_in (SYS_RST_IN),
      .dv (dv.gen)
   );

   // ==========================================================
   // 24 kHz slow clock, runs without the oscillator
   logic [LAZY_W-1:0] lazy_cnt_ff;
   logic lazy_lvl_ff;
   wire lazy_run = SLEEP_OUT;
   wire lazy_tick = lazy_run && (lazy_cnt_ff == LAZY_W'(LAZY_CYC - 1));
   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         lazy_cnt_ff <= '0;
         lazy_lvl_ff <= 1'h0;
      end else if (!lazy_run || lazy_tick) begin
         lazy_cnt_ff <= '0;
         lazy_lvl_ff <= lazy_run & ~lazy_lvl_ff;  // [R8]
      end else begin
         lazy_cnt_ff <= lazy_cnt_ff + LAZY_W'(1);
      end
   end

   // ==========================================================
   // clock output select
   // asleep: slow clock unless disabled, then held low  [R6] [R8] [R14]
   wire nxt_clk = dv.run ? dv.lvl :
                  (SLEEP_OUT && !slow_dis_ff) ? lazy_lvl_ff : 1'h0;
   always_ff @(posedge CORE_CLK_IN or posedge SYS_RST_IN) begin
      if (SYS_RST_IN) begin
         CLK_OUT <= 1'h0;
      end else begin
         CLK_OUT <= nxt_clk;
      end
   end

   // ==========================================================
   // checks
   sequence s_enter_req;
      state_ff == ST_RUN && sleep_fall && !por_hold;
   endsequence
   sequence s_entered;
      state_ff == ST_ENTER && cnt_ff == '0;
   endsequence
   a_enter_start: assert property (s_enter_req |=> s_entered)  // [R7]
      else $error("sleep request did not start the delay");
   a_sleep_delay: assert property ($rose(SLEEP_OUT) |->
      $past(state_ff) == ST_ENTER &&
      $past(cnt_ff) == CNT_W'(SUSP_CYC - 1))  // [R7]
      else $error("sleep output changed at the wrong time");
   a_wake_delay: assert property ($fell(SLEEP_OUT) && !$past(por_hold)
      |-> $past(state_ff) == ST_WAKE &&
      $past(cnt_ff) == CNT_W'(WAKE_CYC - 1))  // [R9]
      else $error("sleep output cleared at the wrong time");
   a_osc_sleep: assert property (state_ff == ST_SLEEP &&
      $past(state_ff) == ST_SLEEP |-> !OSC_EN_OUT && !PLL_EN_OUT)  // [R3]
      else $error("oscillator running while asleep");
   a_osc_ctrl: assert property (!osc_run_ff ##1 !osc_run_ff
      |-> !OSC_EN_OUT)  // [R4]
      else $error("oscillator on with run bit clear");
   a_lazy_out: assert property (state_ff == ST_SLEEP &&
      $past(state_ff) == ST_SLEEP && !$past(slow_dis_ff)
      |-> CLK_OUT == $past(lazy_lvl_ff))  // [R8]
      else $error("slow clock missing while asleep");
   a_lazy_rate: assert property (lazy_tick ##1 SLEEP_OUT
      |-> lazy_lvl_ff != $past(lazy_lvl_ff))  // [R8]
      else $error("slow clock did not toggle");
   a_static_sleep: assert property (state_ff == ST_SLEEP &&
      $past(state_ff) == ST_SLEEP && slow_dis_ff |=> !CLK_OUT)  // [R14]
      else $error("clock output moved with slow clock disabled");
   a_start_quiet: assert property (state_ff == ST_POWERUP
      |=> !CLK_OUT)  // [R10]
      else $error("clock output before start delay");
   a_por_clear: assert property (por_hold |=> state_ff == ST_POWERUP &&
      EP_ENABLE_OUT == EP_CFG_RST && por_seen_ff)  // [R11]
      else $error("supply dip did not reset the block");
   a_ep_ctrl: assert property (EP_ENABLE_OUT[0])  // [R12]
      else $error("control endpoint disabled");
   a_pll_rate: assert property (pll_tick |=> !pll_tick)  // [R1]
      else $error("pll ticks faster than 96 MHz");
endmodule

// ---- tb/clk_sink.sv ----
/*
 far-side clock receiver: counts rising edges of the clock output.
 assumes the output is registered on the core clock that samples it.
*/
module clk_sink (
   input wire logic clk_in,
   input wire logic rst_in,
   input wire logic mclk_in,
   output int edges_out
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_ff;
   // edge count seen by the far side
   always_ff @(posedge clk_in or posedge rst_in) begin
      if (rst_in) begin
         last_ff <= 1'b0;
         edges_out <= 0;
      end else begin
         last_ff <= mclk_in;
         if (mclk_in && !last_ff) edges_out <= edges_out + 1;
      end
   end
endmodule

// ---- tb/usb_device_clock_suspend_control_bench.sv ----
/*
 bench of the clock and suspend control block.
 assumes shortened delay parameters and the register map of the package.
*/
`define CMP(a, e) begin compares++; if ((a) !== (e)) begin miscompares++; \
 $display("BAD t=%0t got %h exp %h", $time, a, e); end end
module usb_device_clock_suspend_control_bench;
   import clk_ctrl_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 0, rst = 1, awv = 0, wv = 0, arv = 0, brdy = 0, rrdy = 0;
   logic wk = 0, vl = 0, obs_v = 0, bv, rv, co, sl, oe, pe, st;
   logic aw_r, w_r, ar_r;
   logic [ADDR_W-1:0] awa = 4'h0, ara = 4'h0;
   logic [3:0] ws = 4'hF;
   logic [31:0] wd = 32'h0, obs = 32'h0, rd, e;
   logic [1:0] br, rr;
   logic [EP_W-1:0] ep;
   logic [31:0] q[$];
   int miscompares = 0, compares = 0, edges, c, d;
   clock_suspend_ctrl #(.SUSP_CYC(40), .WAKE_CYC(20), .START_CYC(20),
      .STABLE_CYC(30), .LAZY_CYC(4)) uut (
      .CORE_CLK_IN(clk), .SYS_RST_IN(rst), .AXI_AWVALID_IN(awv),
      .AXI_AWREADY_OUT(aw_r), .AXI_AWADDR_IN(awa), .AXI_WVALID_IN(wv),
      .AXI_WREADY_OUT(w_r), .AXI_WDATA_IN(wd), .AXI_WSTRB_IN(ws),
      .AXI_BVALID_OUT(bv), .AXI_BREADY_IN(brdy), .AXI_BRESP_OUT(br),
      .AXI_ARVALID_IN(arv), .AXI_ARREADY_OUT(ar_r), .AXI_ARADDR_IN(ara),
      .AXI_RVALID_OUT(rv), .AXI_RREADY_IN(rrdy), .AXI_RDATA_OUT(rd),
      .AXI_RRESP_OUT(rr), .WAKE_IN(wk), .VCC_LOW_IN(vl), .CLK_OUT(co),
      .SLEEP_OUT(sl), .OSC_EN_OUT(oe), .PLL_EN_OUT(pe),
      .CLK_STABLE_OUT(st), .EP_ENABLE_OUT(ep));
   clk_sink sink (.clk_in(clk), .rst_in(rst), .mclk_in(co),
      .edges_out(edges));
   initial begin
      forever #2.5 clk = ~clk;
   end
   // ==========================================================
   // tasks
   task automatic xfer(input bit w, input logic [3:0] a,
      input logic [31:0] dat, input logic [31:0] ex);
      bit p, s, t, r;
      q.push_back(ex);
      if (w) begin
         awv <= 1; wv <= 1; awa <= a; wd <= dat; brdy <= 1;
      end else begin
         arv <= 1; ara <= a; rrdy <= 1;
      end
      do begin
         #4;
         p = awv && aw_r; s = wv && w_r; t = arv && ar_r;
         r = (brdy && bv) || (rrdy && rv);
         @(posedge clk);
         if (p) awv <= 0;
         if (s) wv <= 0;
         if (t) arv <= 0;
         if (r) begin
            brdy <= 0; rrdy <= 0;
         end
      end while (!r);
      @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] a, input logic [31:0] ex);
      q.push_back(ex);
      obs <= a; obs_v <= 1;
      @(posedge clk) obs_v <= 0;
      @(posedge clk);
   endtask
   task automatic cnt(input int n);
      int s0;
      s0 = edges;
      repeat (n) @(posedge clk);
      c = edges - s0;
   endtask
   task automatic wt(input logic v);
      int i;
      for (i = 0; i < 1000 && sl !== v; i++) @(posedge clk);
      chk(sl, v);
   endtask
   task automatic near(input int x);
      chk(c >= x - 2 && c <= x + 2, 1);
   endtask
   task automatic sleep_wake(input logic [31:0] cfg, input int x);
      xfer(1, REG_CONFIG, cfg, RESP_OKAY);
      xfer(1, REG_MODE, 1, RESP_OKAY);
      xfer(1, REG_MODE, 0, RESP_OKAY);
      wt(1);
      chk({oe, pe}, 0);
      cnt(200);
      near(x);
      wk <= 1;
      repeat (2) @(posedge clk);
      wk <= 0;
      wt(0);
      cnt(200);
      near(48);
   endtask
   task automatic complete_run;
      $display("compares %0d miscompares %0d", compares, miscompares);
      if (miscompares == 0 && compares > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   // ==========================================================
   // result monitor
   always @(negedge clk) begin
      if ((bv && brdy) || (rv && rrdy) || obs_v) begin
         e = q.pop_front();
         `CMP(obs_v ? obs : (rv && rrdy) ? rd : {30'h0, br}, e)
      end
   end
   initial begin
      #150000;
      miscompares++;
      complete_run;
   end
   // ==========================================================
   // tests
   initial begin
      d = $urandom(32'h4495);
      repeat (2) @(posedge clk);
      rst <= 0;
      @(posedge clk);
      cnt(15);
      chk(c, 0);
      xfer(0, REG_CONFIG, 0, 32'h1);
      xfer(0, REG_EP_CFG, 0, 32'h1);
      xfer(1, 4'h2, 0, RESP_SLVERR);
      repeat (60) @(posedge clk);
      chk(st, 1);
      $display("test reset done");
      for (int k = 0; k < 3; k++) begin
         d = (k == 0) ? 0 : (k == 1) ? 15 : $urandom % 16;
         xfer(1, REG_CONFIG, (d << CFG_DIV_LSB) | 1, RESP_OKAY);
         cnt(1000);
         near(240 / (d + 1));
      end
      $display("test divider done");
      sleep_wake(32'h1, 25);
      sleep_wake(32'h3, 0);
      $display("test suspend done");
      xfer(1, REG_CONFIG, 0, RESP_OKAY);
      repeat (3) @(posedge clk);
      cnt(100);
      chk({c[7:0], oe}, 0);
      xfer(1, REG_EP_CFG, 32'hFFFF, RESP_OKAY);
      chk(ep, 16'hFFFF);
      vl <= 1;
      repeat (POR_LOW_CYC + 20) @(posedge clk);
      vl <= 0;
      @(posedge clk);
      chk(ep, 16'h0001);
      xfer(0, REG_CONFIG, 0, 32'h1);
      xfer(0, REG_STATUS, 0, 32'hA);
      ws <= 4'hE;
      xfer(1, REG_CONFIG, 0, RESP_OKAY);
      ws <= 4'hF;
      xfer(0, REG_CONFIG, 0, 32'h1);
      $display("test dip done");
      complete_run;
   end
endmodule
